// ==== logic/dpr_pkg.sv ====
// Shared constants, types and decode helpers for the dual-port memory block.
package dpr_pkg;

	// Memory organisation.
	localparam int DATA_W = 16;
	localparam int ADDR_W = 10;
	localparam int DEPTH  = 1024;

	// Register port geometry.
	localparam int REG_AW = 8;
	localparam int REG_DW = 32;

	// Register offsets (byte addresses, one aligned word each).
	localparam logic [REG_AW-1:0] OFS_CFG_A   = 8'h00;
	localparam logic [REG_AW-1:0] OFS_CFG_B   = 8'h04;
	localparam logic [REG_AW-1:0] OFS_SRVAL_A = 8'h08;
	localparam logic [REG_AW-1:0] OFS_SRVAL_B = 8'h0C;
	localparam logic [REG_AW-1:0] OFS_STATUS  = 8'h10;
	localparam logic [REG_AW-1:0] OFS_COUNT   = 8'h14;

	// Port configuration fields.
	localparam int CFG_OUT_REG_BIT     = 0;
	localparam int CFG_WRITE_FIRST_BIT = 1;
	localparam int CFG_PRIO_REGCE_BIT  = 2;
	localparam int CFG_W               = 3;

	// Collision status fields.
	localparam int ST_RW_A_BIT = 0;
	localparam int ST_RW_B_BIT = 1;
	localparam int ST_WW_BIT   = 2;
	localparam int ST_W        = 3;

	// Values after reset.
	localparam logic [CFG_W-1:0]  CFG_RESET    = 3'h2;
	localparam logic [DATA_W-1:0] SRVAL_RESET  = 16'h0000;
	localparam logic [ST_W-1:0]   STATUS_RESET = 3'h0;
	localparam logic [15:0]       COUNT_RESET  = 16'h0000;
	localparam logic [REG_DW-1:0] RDATA_RESET  = 32'h0000_0000;

	// What one port does on a clock edge.
	typedef enum logic [1:0] {
		OP_HOLD,
		OP_RESET,
		OP_READ,
		OP_WRITE
	} dpr_op_t;

	// Latch reset outranks everything; without port enable the latch holds.
	function automatic dpr_op_t dpr_decode(input logic pe, input logic we, input logic rst);
		if (rst) begin
			return OP_RESET;
		end else if (!pe) begin
			return OP_HOLD;
		end else if (we) begin
			return OP_WRITE;
		end
		return OP_READ;
	endfunction : dpr_decode

endpackage : dpr_pkg

// ==== logic/dpr_mem.sv ====
// Storage array with the per-port latch stage of the dual-port memory.
`timescale 1ns/1ps
module dpr_mem
(
	// Clock.
	input  wire logic                       clock,
	// Port A controls.
	input  wire logic                       pe_a,
	input  wire logic                       we_a,
	input  wire logic                       rst_a,
	input  wire logic                       wf_a,
	input  wire logic [dpr_pkg::DATA_W-1:0] srval_a,
	input  wire logic [dpr_pkg::ADDR_W-1:0] addr_a,
	input  wire logic [dpr_pkg::DATA_W-1:0] din_a,
	output logic      [dpr_pkg::DATA_W-1:0] q_a,
	// Port B controls.
	input  wire logic                       pe_b,
	input  wire logic                       we_b,
	input  wire logic                       rst_b,
	input  wire logic                       wf_b,
	input  wire logic [dpr_pkg::DATA_W-1:0] srval_b,
	input  wire logic [dpr_pkg::ADDR_W-1:0] addr_b,
	input  wire logic [dpr_pkg::DATA_W-1:0] din_b,
	output logic      [dpr_pkg::DATA_W-1:0] q_b
);

	import dpr_pkg::*;

	logic [DATA_W-1:0] mem [DEPTH];
	dpr_op_t           op_a;
	dpr_op_t           op_b;
	logic              ww_hit;

	assign op_a   = dpr_decode(pe_a, we_a, rst_a);
	assign op_b   = dpr_decode(pe_b, we_b, rst_b);
	assign ww_hit = pe_a && we_a && pe_b && we_b && (addr_a == addr_b);

	// Writes commit even under latch reset; a same-word double write stores a mix of both.
	always_ff @(posedge clock) begin
		if (ww_hit) begin
			mem[addr_a] <= din_a ^ din_b;
		end else begin
			if (pe_a && we_a) begin
				mem[addr_a] <= din_a;
			end
			if (pe_b && we_b) begin
				mem[addr_b] <= din_b;
			end
		end
	end

	// Port A latch: reads see the word as it stood before any write on this edge.
	always_ff @(posedge clock) begin
		case (op_a)
			OP_RESET: q_a <= srval_a;
			OP_READ:  q_a <= mem[addr_a];
			OP_WRITE: q_a <= wf_a ? din_a : q_a;
			default:  q_a <= q_a;
		endcase
	end

	// Port B latch, same behaviour as port A.
	always_ff @(posedge clock) begin
		case (op_b)
			OP_RESET: q_b <= srval_b;
			OP_READ:  q_b <= mem[addr_b];
			OP_WRITE: q_b <= wf_b ? din_b : q_b;
			default:  q_b <= q_b;
		endcase
	end

endmodule : dpr_mem

// ==== logic/dpr_top.sv ====
// Dual-port memory top: output registers, collision tracking and configuration registers.
//
// Overview of operation
// - Reset-first priority: reset loads reset value, else enable loads latch, else hold.
// - Enable-first priority: no enable holds; enable with reset loads reset value.
// - Both ports touching one word in one cycle is a collision.
// - Two reads of one word both return the stored data.
// - Write beside a read still stores; the read result is flagged undefined.
// - A read on the next cycle after such a collision is reliable.
// - Two writes to one word leave that word undefined, without harm.
// - Both ports pass-through: each output shows its own write data anyway.
// - Latched mode with no enable, write or reset keeps the output.
// - Latch reset sets the output to the reset value on the next edge.
// - Read with enable and no write shows the addressed word next cycle.
// - Latch reset during a read gives the reset value instead of data.
// - Write stores input; output shows it in pass-through, keeps it in hold mode.
// - Write under latch reset still stores; output takes the reset value.
// - With output register on, a transaction spans three clock edges.
// - Output register select: 0 one cycle read latency, 1 two cycles.
`timescale 1ns/1ps
module dpr_top
	import dpr_pkg::*;
(
	// Clock and reset.
	input  wire logic                       clock,
	input  wire logic                       reset,
	// Register port.
	input  wire logic [dpr_pkg::REG_AW-1:0] reg_addr,
	input  wire logic [dpr_pkg::REG_DW-1:0] reg_wdata,
	input  wire logic                       reg_write,
	input  wire logic                       reg_read,
	output logic      [dpr_pkg::REG_DW-1:0] reg_rdata,
	// Memory port A.
	input  wire logic                       pe_a,
	input  wire logic                       we_a,
	input  wire logic [dpr_pkg::ADDR_W-1:0] addr_a,
	input  wire logic [dpr_pkg::DATA_W-1:0] din_a,
	input  wire logic                       rstlatch_a,
	input  wire logic                       rstreg_a,
	input  wire logic                       outregce_a,
	output logic      [dpr_pkg::DATA_W-1:0] dout_a,
	output logic                            rd_invalid_a,
	// Memory port B.
	input  wire logic                       pe_b,
	input  wire logic                       we_b,
	input  wire logic [dpr_pkg::ADDR_W-1:0] addr_b,
	input  wire logic [dpr_pkg::DATA_W-1:0] din_b,
	input  wire logic                       rstlatch_b,
	input  wire logic                       rstreg_b,
	input  wire logic                       outregce_b,
	output logic      [dpr_pkg::DATA_W-1:0] dout_b,
	output logic                            rd_invalid_b,
	// Collision event.
	output logic                            ww_collision
);

	import dpr_pkg::*;

	// Output register step, shared by both ports.
	// Keeping the priority decode in one place stops the two ports drifting apart.
	// The caller passes the current value so that a hold is an explicit choice.
	function automatic logic [DATA_W-1:0] out_step(
		input logic              prio_regce,
		input logic              rst,
		input logic              ce,
		input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] latch,
		input logic [DATA_W-1:0] srval
	);
		if (prio_regce) begin
			if (!ce) begin
				return cur;
			end
			return rst ? srval : latch;
		end
		if (rst) begin
			return srval;
		end
		return ce ? latch : cur;
	endfunction : out_step

	// Whether the output register takes the latch value this edge (carries the flag along).
	// The invalid flag must move exactly when the data moves, or it would mislabel words.
	function automatic logic out_loads(
		input logic prio_regce,
		input logic rst,
		input logic ce
	);
		return ce && !rst && (prio_regce || !rst);
	endfunction : out_loads

	// Configuration and status registers.
	// All of them sit in the one clock domain, so software sees no crossing hazards.
	logic [CFG_W-1:0]  cfg_a;
	logic [CFG_W-1:0]  cfg_b;
	logic [DATA_W-1:0] srval_a;
	logic [DATA_W-1:0] srval_b;
	logic [ST_W-1:0]   status;
	logic [15:0]       count;

	// Latch stage and output register state.
	// Each output register carries its own invalid flag alongside the data word.
	logic [DATA_W-1:0] q_a;
	logic [DATA_W-1:0] q_b;
	logic [DATA_W-1:0] oreg_a;
	logic [DATA_W-1:0] oreg_b;
	logic              inv_latch_a;
	logic              inv_latch_b;
	logic              inv_oreg_a;
	logic              inv_oreg_b;

	// Collision decode for the current edge.
	logic              same_word;
	logic              rw_hit_a;
	logic              rw_hit_b;
	logic              ww_hit;
	logic [ST_W-1:0]   next_status;

	// Both ports run in the same clock, so a collision is a same-cycle, same-word access.
	// A variant with one clock per port would need a timed window here instead.
	// The limitation is deliberate: one shared clock keeps the decode exact and cheap.
	assign same_word = pe_a && pe_b && (addr_a == addr_b);
	assign rw_hit_a  = same_word && !we_a && we_b;
	assign rw_hit_b  = same_word && !we_b && we_a;
	assign ww_hit    = same_word && we_a && we_b;

	// Storage and latch stage; each port is decoded on its own.
	// The memory module owns the array so that its read data always leave a register.
	dpr_mem u_mem (
		.clock   (clock),
		.pe_a    (pe_a),
		.we_a    (we_a),
		.rst_a   (rstlatch_a),
		.wf_a    (cfg_a[CFG_WRITE_FIRST_BIT]),
		.srval_a (srval_a),
		.addr_a  (addr_a),
		.din_a   (din_a),
		.q_a     (q_a),
		.pe_b    (pe_b),
		.we_b    (we_b),
		.rst_b   (rstlatch_b),
		.wf_b    (cfg_b[CFG_WRITE_FIRST_BIT]),
		.srval_b (srval_b),
		.addr_b  (addr_b),
		.din_b   (din_b),
		.q_b     (q_b)
	);

	// Invalid flags follow the latch: only a read under a colliding write is suspect.
	// A latch reset replaces the data with a known value, so it clears the flag.
	// The flag is a hint for the fabric; the stored word itself is never repaired.
	always_ff @(posedge clock) begin
		if (reset) begin
			inv_latch_a <= 1'b0;
		end else if (rstlatch_a) begin
			inv_latch_a <= 1'b0;
		end else if (pe_a && !we_a) begin
			inv_latch_a <= rw_hit_a;
		end else if (pe_a) begin
			inv_latch_a <= 1'b0;
		end
	end

	// Port B invalid flag, mirror of port A.
	always_ff @(posedge clock) begin
		if (reset) begin
			inv_latch_b <= 1'b0;
		end else if (rstlatch_b) begin
			inv_latch_b <= 1'b0;
		end else if (pe_b && !we_b) begin
			inv_latch_b <= rw_hit_b;
		end else if (pe_b) begin
			inv_latch_b <= 1'b0;
		end
	end

	// Port A output register: one extra stage after the latch.
	// It costs a cycle of latency but cuts the path from the array to the pins.
	// The flag follows the same priority as the data so the two never disagree.
	always_ff @(posedge clock) begin
		if (reset) begin
			oreg_a     <= SRVAL_RESET;
			inv_oreg_a <= 1'b0;
		end else begin
			oreg_a <= out_step(cfg_a[CFG_PRIO_REGCE_BIT], rstreg_a, outregce_a,
				oreg_a, q_a, srval_a);
			if (out_loads(cfg_a[CFG_PRIO_REGCE_BIT], rstreg_a, outregce_a)) begin
				inv_oreg_a <= inv_latch_a;
			end else if (rstreg_a && (outregce_a || !cfg_a[CFG_PRIO_REGCE_BIT])) begin
				inv_oreg_a <= 1'b0;
			end
		end
	end

	// Port B output register, mirror of port A.
	always_ff @(posedge clock) begin
		if (reset) begin
			oreg_b     <= SRVAL_RESET;
			inv_oreg_b <= 1'b0;
		end else begin
			oreg_b <= out_step(cfg_b[CFG_PRIO_REGCE_BIT], rstreg_b, outregce_b,
				oreg_b, q_b, srval_b);
			if (out_loads(cfg_b[CFG_PRIO_REGCE_BIT], rstreg_b, outregce_b)) begin
				inv_oreg_b <= inv_latch_b;
			end else if (rstreg_b && (outregce_b || !cfg_b[CFG_PRIO_REGCE_BIT])) begin
				inv_oreg_b <= 1'b0;
			end
		end
	end

	// Output select: latch for one cycle of latency, register for two.
	// The select is meant to be static; flipping it mid-read can show a stale word.
	// Both stages keep running either way, so a later switch needs no warm-up.
	always_comb begin
		dout_a       = cfg_a[CFG_OUT_REG_BIT] ? oreg_a : q_a;
		rd_invalid_a = cfg_a[CFG_OUT_REG_BIT] ? inv_oreg_a : inv_latch_a;
		dout_b       = cfg_b[CFG_OUT_REG_BIT] ? oreg_b : q_b;
		rd_invalid_b = cfg_b[CFG_OUT_REG_BIT] ? inv_oreg_b : inv_latch_b;
	end

	// Double-write event, registered so it lines up with the corrupted word.
	// It is a pulse, not a level; software that needs history reads the sticky status.
	always_ff @(posedge clock) begin
		if (reset) begin
			ww_collision <= 1'b0;
		end else begin
			ww_collision <= ww_hit;
		end
	end

	// Port configuration; changing it mid-traffic only affects later edges.
	// Writes to unknown offsets fall through to the default branch and change nothing.
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_a   <= CFG_RESET;
			cfg_b   <= CFG_RESET;
			srval_a <= SRVAL_RESET;
			srval_b <= SRVAL_RESET;
		end else if (reg_write) begin
			case (reg_addr)
				OFS_CFG_A:   cfg_a   <= reg_wdata[CFG_W-1:0];
				OFS_CFG_B:   cfg_b   <= reg_wdata[CFG_W-1:0];
				OFS_SRVAL_A: srval_a <= reg_wdata[DATA_W-1:0];
				OFS_SRVAL_B: srval_b <= reg_wdata[DATA_W-1:0];
				default:     cfg_a   <= cfg_a;
			endcase
		end
	end

	// Sticky collision flags; a new event in the clearing cycle survives the clear.
	// A read beside its own latch reset is not flagged, since the reader sees a known value.
	always_comb begin
		next_status = status;
		if (reg_write && (reg_addr == OFS_STATUS)) begin
			next_status = status & ~reg_wdata[ST_W-1:0];
		end
		next_status[ST_RW_A_BIT] = next_status[ST_RW_A_BIT] | (rw_hit_a && !rstlatch_a);
		next_status[ST_RW_B_BIT] = next_status[ST_RW_B_BIT] | (rw_hit_b && !rstlatch_b);
		next_status[ST_WW_BIT]   = next_status[ST_WW_BIT] | ww_hit;
	end

	// Status register.
	always_ff @(posedge clock) begin
		if (reset) begin
			status <= STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// Collision counter wraps; software reads differences, so wrap is harmless.
	// Read-beside-write and double-write collisions add one, even when a latch reset hides the bad data.
	always_ff @(posedge clock) begin
		if (reset) begin
			count <= COUNT_RESET;
		end else if (reg_write && (reg_addr == OFS_COUNT)) begin
			count <= COUNT_RESET;
		end else if (rw_hit_a || rw_hit_b || ww_hit) begin
			count <= count + 16'h0001;
		end
	end

	// Read data stand for the one cycle after the strobe; unmapped words read zero.
	// Returning to zero between reads lets a careless master spot a missed cycle.
	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata <= RDATA_RESET;
		end else if (reg_read) begin
			case (reg_addr)
				OFS_CFG_A:   reg_rdata <= {29'h0000_0000, cfg_a};
				OFS_CFG_B:   reg_rdata <= {29'h0000_0000, cfg_b};
				OFS_SRVAL_A: reg_rdata <= {16'h0000, srval_a};
				OFS_SRVAL_B: reg_rdata <= {16'h0000, srval_b};
				OFS_STATUS:  reg_rdata <= {29'h0000_0000, status};
				OFS_COUNT:   reg_rdata <= {16'h0000, count};
				default:     reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= RDATA_RESET;
		end
	end

endmodule : dpr_top

// ==== bench/dpr_fabric_model.sv ====
// Fabric-side model that drives the control and data pins of both memory ports.
`timescale 1ns/1ps
module dpr_fabric_model
(
	// Controls, index 0 is port A and index 1 is port B.
	output logic [1:0]                      pe,
	output logic [1:0]                      we,
	output logic [1:0]                      rl,
	output logic [1:0]                      rr,
	output logic [1:0]                      ce,
	// Address and write data per port.
	output logic [1:0][dpr_pkg::ADDR_W-1:0] addr,
	output logic [1:0][dpr_pkg::DATA_W-1:0] din
);
	import dpr_pkg::*;
	// Latch reset starts high so both outputs come up at a known value.
	initial begin
		{pe, we, rr, ce} = 8'h00;
		rl = 2'h3;
		addr = '0;
		din = '0;
	end
	// One operation per call; double writes to one word come only from the caller.
	task drive(input int p, input logic v_pe, v_we, v_rl,
		input logic [ADDR_W-1:0] v_a, input logic [DATA_W-1:0] v_d);
		pe[p] <= v_pe;
		we[p] <= v_we;
		rl[p] <= v_rl;
		addr[p] <= v_pe ? v_a : ~addr[p]; // Unused pins never keep a stale value.
		din[p] <= (v_pe && v_we) ? v_d : ~din[p];
	endtask : drive
	// Output register controls of one port.
	task oreg(input int p, input logic v_rr, v_ce);
		rr[p] <= v_rr;
		ce[p] <= v_ce;
	endtask : oreg
endmodule : dpr_fabric_model

// ==== bench/dpr_top_monitor.sv ====
// Checker for port A output behaviour and collision reporting.
`timescale 1ns/1ps
module dpr_top_monitor
(
	// Clock, reset and register writes.
	input wire logic                       clock,
	input wire logic                       reset,
	input wire logic [dpr_pkg::REG_AW-1:0] reg_addr,
	input wire logic [dpr_pkg::REG_DW-1:0] reg_wdata,
	input wire logic                       reg_write,
	// Port A.
	input wire logic                       pe_a,
	input wire logic                       we_a,
	input wire logic [dpr_pkg::ADDR_W-1:0] addr_a,
	input wire logic [dpr_pkg::DATA_W-1:0] din_a,
	input wire logic                       rstlatch_a,
	input wire logic                       rstreg_a,
	input wire logic                       outregce_a,
	input wire logic [dpr_pkg::DATA_W-1:0] dout_a,
	input wire logic                       rd_invalid_a,
	// Port B and collision event.
	input wire logic                       pe_b,
	input wire logic                       we_b,
	input wire logic [dpr_pkg::ADDR_W-1:0] addr_b,
	input wire logic                       ww_collision
);
	import dpr_pkg::*;
	logic [CFG_W-1:0]  cfg_a;
	logic [DATA_W-1:0] srv_a;
	logic              ww_now;
	// Same-word double write as seen on the pins this cycle.
	assign ww_now = pe_a && we_a && pe_b && we_b && (addr_a == addr_b);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Shadow of port A settings, since the checker cannot look inside.
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_a <= CFG_RESET;
			srv_a <= SRVAL_RESET;
		end else if (reg_write && reg_addr == OFS_CFG_A) begin
			cfg_a <= reg_wdata[CFG_W-1:0];
		end else if (reg_write && reg_addr == OFS_SRVAL_A) begin
			srv_a <= reg_wdata[DATA_W-1:0];
		end
	end
	sequence s_latch_reset;
		cfg_a[0] && rstlatch_a && !reg_write;
	endsequence
	sequence s_reg_load;
		outregce_a && !rstreg_a;
	endsequence
	AST_HOLD_LATCH:
	assert property (!cfg_a[0] && !reg_write && !pe_a && !rstlatch_a |=> $stable(dout_a))
		else $error("latched output moved on a hold");
	AST_LATCH_RESET:
	assert property (!cfg_a[0] && rstlatch_a && !reg_write |=> dout_a == srv_a)
		else $error("latch reset did not give the reset value");
	AST_WRITE_FIRST:
	assert property (!cfg_a[0] && cfg_a[1] && pe_a && we_a && !rstlatch_a |=> dout_a == $past(din_a))
		else $error("pass-through write not shown");
	AST_NO_CHANGE:
	assert property (!cfg_a[0] && !cfg_a[1] && pe_a && we_a && !rstlatch_a |=> $stable(dout_a))
		else $error("hold-mode write changed the output");
	AST_REG_RESET_FIRST:
	assert property (cfg_a[0] && !cfg_a[2] && rstreg_a && !reg_write |=> dout_a == srv_a)
		else $error("reset-first output register missed reset");
	AST_REG_HOLD:
	assert property (cfg_a[0] && !reg_write && !outregce_a && (cfg_a[2] || !rstreg_a)
		|=> $stable(dout_a))
		else $error("output register moved without enable");
	AST_REG_GATED:
	assert property (cfg_a[0] && cfg_a[2] && rstreg_a && outregce_a && !reg_write
		|=> dout_a == srv_a)
		else $error("enable-first output register missed reset");
	AST_REG_PIPE:
	assert property (s_latch_reset ##1 s_reg_load |=> dout_a == srv_a)
		else $error("registered path not three edges long");
	AST_WW_PULSE:
	assert property (ww_collision == $past(ww_now))
		else $error("double write pulse wrong");
	AST_RW_INVALID:
	assert property (!cfg_a[0] && pe_a && !we_a && !rstlatch_a && pe_b && we_b
		&& addr_a == addr_b |=> rd_invalid_a)
		else $error("read beside a write not flagged");
endmodule : dpr_top_monitor
bind dpr_top dpr_top_monitor u_mon (.clock(clock), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .pe_a(pe_a), .we_a(we_a), .addr_a(addr_a),
	.din_a(din_a), .rstlatch_a(rstlatch_a), .rstreg_a(rstreg_a), .outregce_a(outregce_a),
	.dout_a(dout_a), .rd_invalid_a(rd_invalid_a), .pe_b(pe_b), .we_b(we_b), .addr_b(addr_b),
	.ww_collision(ww_collision));

// ==== bench/dpr_top_tb.sv ====
// Self-checking bench for the dual-port memory top.
`timescale 1ns/1ps
module dpr_top_tb;
	import dpr_pkg::*;
	logic                   clock = 1'b0;
	logic                   reset = 1'b1;
	logic [REG_AW-1:0]      reg_addr = 8'h00;
	logic [REG_DW-1:0]      reg_wdata = 32'h0;
	logic                   reg_write = 1'b0;
	logic                   reg_read = 1'b0;
	logic [REG_DW-1:0]      reg_rdata;
	logic [1:0]             pe, we, rl, rreg, ce, inv;
	logic [1:0][ADDR_W-1:0] addr;
	logic [1:0][DATA_W-1:0] din, dout;
	logic                   ww;
	int                     bad_count = 0;
	int                     cmp_count = 0;
	int                     cyc = 0;
	// Free-running 100 MHz clock.
	always #5 clock = ~clock;
	dpr_fabric_model fab (.pe(pe), .we(we), .rl(rl), .rr(rreg), .ce(ce), .addr(addr), .din(din));
	dpr_top DUT (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.pe_a(pe[0]), .we_a(we[0]), .addr_a(addr[0]), .din_a(din[0]), .rstlatch_a(rl[0]),
		.rstreg_a(rreg[0]), .outregce_a(ce[0]), .dout_a(dout[0]), .rd_invalid_a(inv[0]),
		.pe_b(pe[1]), .we_b(we[1]), .addr_b(addr[1]), .din_b(din[1]), .rstlatch_b(rl[1]),
		.rstreg_b(rreg[1]), .outregce_b(ce[1]), .dout_b(dout[1]), .rd_invalid_b(inv[1]),
		.ww_collision(ww));
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task rw(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : rw
	task rr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
		@(posedge clock);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, e);
	endtask : rr
	// Both ports act in one cycle, then both hold; outputs are looked at after the taking edge.
	task dual(input logic p0, w0, input logic [ADDR_W-1:0] a0, input logic [DATA_W-1:0] d0,
		input logic p1, w1, input logic [ADDR_W-1:0] a1, input logic [DATA_W-1:0] d1);
		@(posedge clock);
		fab.drive(0, p0, w0, 0, a0, d0);
		fab.drive(1, p1, w1, 0, a1, d1);
		@(posedge clock);
		fab.drive(0, 0, 0, 0, a0, d0);
		fab.drive(1, 0, 0, 0, a1, d1);
		@(negedge clock);
	endtask : dual
	// One port A operation followed by a hold.
	task run(input logic p, w, l, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		fab.drive(0, p, w, l, a, d);
		@(posedge clock);
		fab.drive(0, 0, 0, 0, a, d);
		@(negedge clock);
	endtask : run
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// A hang is cut short well beyond the roughly 80 cycles the tests need.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		fab.drive(0, 0, 0, 0, 10'h0, 16'h0);
		fab.drive(1, 0, 0, 0, 10'h0, 16'h0);
		rr(OFS_CFG_A, 32'h2);
		rr(OFS_STATUS, 32'h0);
		rr(8'h20, 32'h0);
		rw(OFS_SRVAL_A, 32'hA5A5);
		run(0, 0, 1, 10'h0, 16'h0);
		chk(dout[0], 16'hA5A5);
		run(1, 1, 0, 10'h5, 16'h1234);
		chk(dout[0], 16'h1234);
		@(negedge clock);
		chk(dout[0], 16'h1234);
		rw(OFS_CFG_A, 32'h0);
		run(1, 1, 0, 10'h6, 16'hBEEF);
		chk(dout[0], 16'h1234);
		run(1, 0, 0, 10'h6, 16'h0);
		chk(dout[0], 16'hBEEF);
		run(1, 0, 1, 10'h6, 16'h0);
		chk(dout[0], 16'hA5A5);
		run(1, 1, 1, 10'h7, 16'h7777);
		chk(dout[0], 16'hA5A5);
		run(1, 0, 0, 10'h7, 16'h0);
		chk(dout[0], 16'h7777);
		$display("latched mode test done");
		rw(OFS_CFG_A, 32'h2);
		dual(1, 0, 10'h5, 16'h0, 1, 0, 10'h5, 16'h0);
		chk(dout, {16'h1234, 16'h1234});
		dual(1, 0, 10'h5, 16'h0, 1, 1, 10'h5, 16'h4321);
		chk(inv[0], 1'b1);
		run(1, 0, 0, 10'h5, 16'h0);
		chk({inv[0], dout[0]}, 17'h04321);
		dual(1, 1, 10'h8, 16'h00FF, 1, 1, 10'h8, 16'hFF00);
		chk(dout, {16'hFF00, 16'h00FF});
		chk(ww, 1'b1);
		rr(OFS_STATUS, 32'h5);
		dual(1, 1, 10'h5, 16'h5A5A, 1, 0, 10'h5, 16'h0);
		chk(inv[1], 1'b1);
		rr(OFS_COUNT, 32'h3);
		rr(OFS_STATUS, 32'h7);
		rw(OFS_STATUS, 32'h7);
		rr(OFS_STATUS, 32'h0);
		run(1, 0, 0, 10'h8, 16'h0);
		chk(dout[0], 16'hFFFF);
		dual(1, 1, 10'h9, 16'h1111, 1, 1, 10'hA, 16'h2222);
		dual(1, 0, 10'hA, 16'h0, 1, 0, 10'h9, 16'h0);
		chk(dout, {16'h1111, 16'h2222});
		$display("collision test done");
		rw(OFS_CFG_A, 32'h1);
		@(posedge clock);
		fab.oreg(0, 1, 0);
		run(1, 0, 0, 10'h6, 16'h0);
		chk(dout[0], 16'hA5A5);
		@(posedge clock);
		fab.oreg(0, 0, 1);
		@(posedge clock);
		fab.oreg(0, 0, 0);
		@(negedge clock);
		chk(dout[0], 16'hBEEF);
		@(posedge clock);
		fab.drive(0, 0, 0, 1, 10'h0, 16'h0);
		@(posedge clock);
		fab.drive(0, 0, 0, 0, 10'h0, 16'h0);
		fab.oreg(0, 0, 1);
		@(negedge clock);
		chk(dout[0], 16'hBEEF);
		@(posedge clock);
		fab.oreg(0, 0, 0);
		@(negedge clock);
		chk(dout[0], 16'hA5A5);
		rw(OFS_CFG_A, 32'h5);
		rw(OFS_SRVAL_A, 32'h0F0F);
		@(posedge clock);
		fab.oreg(0, 1, 0);
		@(negedge clock);
		@(posedge clock);
		fab.oreg(0, 1, 1);
		@(negedge clock);
		chk(dout[0], 16'hA5A5);
		@(posedge clock);
		fab.oreg(0, 0, 0);
		@(negedge clock);
		chk(dout[0], 16'h0F0F);
		$display("registered mode test done");
		summarize();
	end
endmodule : dpr_top_tb
